// ### src/csr_call_stack.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// (RL1) Return stack holds eight saved program counter entries.
// (RL2) Push on call and interrupt entry; pop on matching return.
// (RL3) Three-bit pointer selects the entry used by push and pop.
// (RL4) Push decrements the pointer; pop increments it.
// (RL5) Each entry is thirteen bits, upper five and lower eight.
// (RL6) Pointer 111 empty; pushes fill 0..7; ninth push is overflow.
// (RL7) Pop returns the top entry, retracing pushes back to 111.
// (RL8) Interrupt return and subroutine return both pop the stack.
// (RL9) Pointer register bit 7 is interrupt enable, reset 0; pointer 111.
// (RL10) Pointer at DF, entries in the system register area.
// (RL11) Software should write 111 to the pointer at program start.
// (RL12) Reset by power-on, watchdog, brown-out, enabled reset pin.
// (RL13) Reset restores registers, halts, clears PC; run from zero.
// (RL14) Flags bits 7:6 give cause: 00 wdt, 10 power, 11 pin.
// (RL15) Reset cause flags stay readable by software after reset.
// (RL16) Power-on: settle, check pin, init, warm up, execute.
// (RL17) With pin reset enabled, stay in reset while the pin is low.
// (RL18) Watchdog overflow resets, inits, warms up, resumes at zero.
// (RL19) Pointer wraps modulo eight; no trap on over or underflow.
module csr_call_stack
  import csr_pkg::*;
#(
  parameter int SETTLE_CYC = CSR_SETTLE_CYC,
  parameter int WARM_CYC = CSR_WARM_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire csr_seq_s seq,
  input wire logic wdt_ovf,
  input wire logic bod_rst,
  input wire logic ext_rst_pin,
  output logic [12:0] ret_pc,
  output logic ret_valid,
  output logic global_irq_enable,
  output logic core_run,
  output logic stack_over
);
  logic [2:0] sp_q;
  logic gie_q;
  logic [2:0] flags_q;
  logic [1:0] cause_q;
  logic ext_en_q;
  logic [12:0] ret_pc_q;
  logic ret_valid_q;
  logic run_q;
  logic over_q;
  logic [7:0] depth_q;
  logic aw_got_q;
  logic w_got_q;
  logic [CSR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic sys_init;
  logic run_w;
  logic [1:0] cause_w;
  logic [12:0] top_rd;
  logic [12:0] sw_rd;

  // Register index decode, shared by the write and the read path.
  function automatic logic idx_in_page(input logic [CSR_ADDR_W-1:0] a);
    return a[CSR_ADDR_W-1:10] == '0;
  endfunction : idx_in_page

  function automatic logic idx_is_stack(input logic [7:0] idx);
    return idx >= CSR_IDX_STK_BASE;
  endfunction : idx_is_stack

  function automatic logic idx_is_reg(input logic [7:0] idx);
    return idx == CSR_IDX_SP || idx == CSR_IDX_FLAGS || idx == CSR_IDX_CFG;
  endfunction : idx_is_reg

  // F0 and F1 belong to entry 7, FE and FF to entry 0; odd is upper.
  function automatic logic [2:0] idx_entry(input logic [7:0] idx);
    return 3'h7 - idx[3:1];
  endfunction : idx_entry

  wire [7:0] waddr8 = awaddr_q[9:2];
  wire [7:0] raddr8 = s_axi_araddr[9:2];
  wire up_hi = idx_in_page(awaddr_q);
  wire ur_hi = idx_in_page(s_axi_araddr);
  wire w_stk = up_hi && idx_is_stack(waddr8);
  wire r_stk = ur_hi && idx_is_stack(raddr8);
  wire w_sp = up_hi && waddr8 == CSR_IDX_SP;
  wire w_fl = up_hi && waddr8 == CSR_IDX_FLAGS;
  wire w_cfg = up_hi && waddr8 == CSR_IDX_CFG;
  wire w_ok = w_stk || (up_hi && idx_is_reg(waddr8));
  wire r_ok = r_stk || (ur_hi && idx_is_reg(raddr8));
  wire [2:0] w_ent = idx_entry(waddr8);
  wire [2:0] r_ent = idx_entry(raddr8);
  wire w_fire = aw_got_q && w_got_q && !bvalid_q;
  wire w_start = w_fire && w_stk;
  wire w_sp_hit = w_fire && w_sp && wstrb_q[0];
  wire w_fl_hit = w_fire && w_fl && wstrb_q[0];

  // Hardware stack operations only while the core runs. [RL2] [RL8]
  wire do_push = run_q && seq.push;
  // A push and a pop in one cycle: the push wins and the pop is dropped.
  wire do_pop = run_q && (seq.pop_sub || seq.pop_irq) && !seq.push;
  // Pointer 111 writes entry 0 down to 000 writing entry 7. [RL6]
  wire [2:0] sp_slot = ~sp_q; // [RL3]
  wire [2:0] sp_next_push = 3'(sp_q - 3'h1); // [RL4] [RL19]
  wire [2:0] sp_next_pop = 3'(sp_q + 3'h1); // [RL4] [RL19]
  // The top entry is the one just above the pointer. [RL7]
  wire [2:0] pop_slot = ~sp_next_pop;
  // Reads wait during a push and while a software stack write owns the shadow read port.
  wire rd_block = do_push || w_start;

  logic [12:0] sw_val;
  always_comb begin
    sw_val = sw_rd;
    if (waddr8[0] == 1'b1) begin
      if (wstrb_q[0]) sw_val[12:8] = wdata_q[4:0]; // [RL5]
    end else begin
      if (wstrb_q[0]) sw_val[7:0] = wdata_q[7:0]; // [RL5]
    end
  end

  // A push owns the write port; a software entry write in the same cycle
  // is lost, so firmware should not patch entries while calls are running.
  wire stk_we = do_push || w_start;
  // The push slot is the entry at the pointer before the decrement. [RL3]
  wire [2:0] stk_wa = do_push ? sp_slot : w_ent;
  wire [12:0] stk_wd = do_push ? seq.pc : sw_val;

  csr_stack_mem u_mem (
    .aclk(aclk),
    .clr(sys_init),
    .we(stk_we),
    .waddr(stk_wa),
    .wdata(stk_wd),
    .raddr(pop_slot),
    .rdata(top_rd)
  );

  csr_stack_mem u_shadow (
    .aclk(aclk),
    .clr(sys_init),
    .we(stk_we),
    .waddr(stk_wa),
    .wdata(stk_wd),
    .raddr(w_start ? w_ent : r_ent),
    .rdata(sw_rd)
  );

  csr_reset_seq #(
    .SETTLE_CYC(SETTLE_CYC),
    .WARM_CYC(WARM_CYC)
  ) u_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .wdt_ovf(wdt_ovf),
    .bod_rst(bod_rst),
    .ext_rst_en(ext_en_q),
    .ext_rst_pin(ext_rst_pin),
    .sys_init(sys_init),
    .run(run_w),
    .cause(cause_w)
  );

  // Pointer and interrupt enable; init holds them at reset values. [RL13]
  // A stack operation beats a software pointer write in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_init) begin
      sp_q <= CSR_SP_RST; // [RL9]
      gie_q <= 1'b0; // [RL9]
    end else begin
      if (do_push) begin
        sp_q <= sp_next_push;
      end else if (do_pop) begin
        sp_q <= sp_next_pop;
      end else if (w_sp_hit) begin
        sp_q <= wdata_q[2:0]; // [RL10]
      end
      if (w_sp_hit) gie_q <= wdata_q[CSR_GIE_BIT]; // [RL9]
    end
  end

  // Return address register and its one-cycle strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_init) begin
      ret_pc_q <= CSR_PC_RST; // [RL13]
      ret_valid_q <= 1'b0;
    end else begin
      ret_valid_q <= do_pop;
      if (do_pop) ret_pc_q <= top_rd; // [RL7]
    end
  end

  // Depth counts live entries so that the ninth push raises the sticky
  // overflow flag; the pointer itself simply wraps.
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_init) begin
      depth_q <= 8'h00;
      over_q <= 1'b0;
    end else if (do_push) begin
      depth_q <= depth_q + 8'h01;
      over_q <= over_q | (depth_q >= 8'(CSR_DEPTH)); // [RL6] [RL19]
    end else if (do_pop) begin
      depth_q <= (depth_q == 8'h00) ? 8'h00 : depth_q - 8'h01;
    end
  end

  // The cause follows the sequencer during init and is kept afterwards,
  // so software can branch on it once the core runs.
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_init) begin
      cause_q <= cause_w; // [RL14] [RL15]
      flags_q <= 3'h0;
    end else if (w_fl_hit) begin
      cause_q <= wdata_q[7:6];
      flags_q <= wdata_q[2:0];
    end
  end

  // The pin enable stands in for a configuration option, so only the bus
  // reset clears it; internal resets leave it as software set it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      run_q <= run_w; // [RL13]
      if (w_fire && w_cfg && wstrb_q[0]) ext_en_q <= wdata_q[0]; // [RL12]
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (w_fire) begin
      aw_got_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_fire) begin
      w_got_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // The write takes effect one cycle after the later half is taken, and
  // the response is raised in that same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= CSR_RESP_OKAY;
    end else if (w_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_ok ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  wire [31:0] rd_stk_word =
      raddr8[0] ? {27'h0, sw_rd[12:8]} : {24'h0, sw_rd[7:0]}; // [RL5]
  wire [31:0] rd_sp_word = {24'h0, gie_q, 4'h0, sp_q}; // [RL9]
  wire [31:0] rd_fl_word = {24'h0, cause_q, 3'h0, flags_q}; // [RL15]
  wire [31:0] rd_cfg_word = {24'h0, 2'h0, run_q, 4'h0, ext_en_q};
  wire [31:0] rd_mux = r_stk ? rd_stk_word :
                       (raddr8 == CSR_IDX_SP) ? rd_sp_word :
                       (raddr8 == CSR_IDX_FLAGS) ? rd_fl_word : rd_cfg_word;

  // Read data is captured with the address, so rvalid follows one cycle
  // later and stands until rready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Unmapped reads answer with an error and zero data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rresp_q <= CSR_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rresp_q <= r_ok ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
      rdata_q <= r_ok ? rd_mux : 32'h00000000;
    end
  end

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q && !rd_block;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign ret_pc = ret_pc_q;
  assign ret_valid = ret_valid_q;
  assign global_irq_enable = gie_q;
  assign core_run = run_q;
  assign stack_over = over_q;
endmodule : csr_call_stack

// ### inc/csr_pkg.sv
package csr_pkg;
  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] CSR_IDX_FLAGS = 8'h86;
  localparam logic [7:0] CSR_IDX_SP = 8'hDF;
  localparam logic [7:0] CSR_IDX_STK_BASE = 8'hF0;
  localparam logic [7:0] CSR_IDX_CFG = 8'hE0;
  localparam int CSR_ADDR_W = 12;
  localparam int CSR_DEPTH = 8;
  localparam int CSR_PC_W = 13;
  localparam logic [2:0] CSR_SP_RST = 3'h7;
  localparam logic [12:0] CSR_PC_RST = 13'h0000;
  localparam int CSR_GIE_BIT = 7;
  localparam logic [1:0] CSR_CAUSE_WDT = 2'h0;
  localparam logic [1:0] CSR_CAUSE_POR = 2'h2;
  localparam logic [1:0] CSR_CAUSE_EXT = 2'h3;
  localparam logic [1:0] CSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;
  localparam real CSR_CLK_MHZ = 125.0;
  localparam real CSR_SETTLE_US = 10.0;
  localparam real CSR_WARM_US = 20.0;
  localparam int CSR_SETTLE_CYC = int'(CSR_SETTLE_US * CSR_CLK_MHZ);
  localparam int CSR_WARM_CYC = int'(CSR_WARM_US * CSR_CLK_MHZ);

  typedef enum logic [2:0] {
    CSR_ST_SETTLE = 3'b000,
    CSR_ST_PIN = 3'b001,
    CSR_ST_INIT = 3'b011,
    CSR_ST_WARM = 3'b010,
    CSR_ST_RUN = 3'b110
  } csr_state_e;

  typedef struct packed {
    logic push;
    logic pop_sub;
    logic pop_irq;
    logic [12:0] pc;
  } csr_seq_s;

  function automatic logic [2:0] csr_idx(input logic [11:0] a);
    return a[4:2];
  endfunction : csr_idx
endpackage : csr_pkg

// ### src/csr_stack_mem.sv
`timescale 1ns/1ps
module csr_stack_mem
  import csr_pkg::*;
(
  input wire logic aclk,
  input wire logic clr,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [12:0] wdata,
  input wire logic [2:0] raddr,
  output logic [12:0] rdata
);
  logic [12:0] mem_q [CSR_DEPTH];

  // Eight thirteen-bit return entries; clearing restores all to zero. [RL1] [RL5]
  genvar g;
  generate
    for (g = 0; g < CSR_DEPTH; g++) begin : g_ent
      always_ff @(posedge aclk) begin
        if (clr) begin
          mem_q[g] <= CSR_PC_RST;
        end else if (we && waddr == 3'(g)) begin
          mem_q[g] <= wdata;
        end
      end
    end
  endgenerate

  assign rdata = mem_q[raddr];
endmodule : csr_stack_mem

// ### src/csr_reset_seq.sv
`timescale 1ns/1ps
module csr_reset_seq
  import csr_pkg::*;
#(
  parameter int SETTLE_CYC = CSR_SETTLE_CYC,
  parameter int WARM_CYC = CSR_WARM_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wdt_ovf,
  input wire logic bod_rst,
  input wire logic ext_rst_en,
  input wire logic ext_rst_pin,
  output logic sys_init,
  output logic run,
  output logic [1:0] cause
);
  csr_state_e st_q, st_d;
  logic [15:0] cnt_q;
  logic [1:0] cause_q;
  wire pin_low = ext_rst_en && !ext_rst_pin;
  // Any source returns to settle; the pin only counts when enabled. [RL12]
  // A low pin during the pin check only stalls; the other sources still
  // restart the sequence there, but the cause is recorded as pin while it is low.
  wire hit = wdt_ovf || bod_rst || (pin_low && st_q != CSR_ST_PIN);
  wire cnt_done = (st_q == CSR_ST_SETTLE) ? (cnt_q >= 16'(SETTLE_CYC - 1))
                                          : (cnt_q >= 16'(WARM_CYC - 1));

  // Supply settle, pin check, init, warm up, then run. [RL16] [RL18]
  always_comb begin
    st_d = st_q;
    case (st_q)
      CSR_ST_SETTLE: if (cnt_done) st_d = CSR_ST_PIN;
      CSR_ST_PIN: if (!pin_low) st_d = CSR_ST_INIT; // [RL17]
      CSR_ST_INIT: st_d = CSR_ST_WARM;
      CSR_ST_WARM: if (cnt_done) st_d = CSR_ST_RUN;
      CSR_ST_RUN: st_d = CSR_ST_RUN;
      default: st_d = CSR_ST_SETTLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CSR_ST_SETTLE;
      cnt_q <= 16'h0000;
      cause_q <= CSR_CAUSE_POR;
    end else if (hit) begin
      st_q <= CSR_ST_SETTLE;
      cnt_q <= 16'h0000;
      // Pin wins over brown-out, which wins over the watchdog. [RL14]
      cause_q <= pin_low ? CSR_CAUSE_EXT :
                 bod_rst ? CSR_CAUSE_POR : CSR_CAUSE_WDT;
    end else begin
      st_q <= st_d;
      cnt_q <= (st_d != st_q) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  assign sys_init = (st_q != CSR_ST_RUN) && (st_q != CSR_ST_WARM);
  assign run = (st_q == CSR_ST_RUN);
  assign cause = cause_q;
endmodule : csr_reset_seq

// ### verif/csr_call_stack_properties.sv
`timescale 1ns/1ps
module csr_call_stack_properties
  import csr_pkg::*;
#(
  parameter int SETTLE_CYC = CSR_SETTLE_CYC,
  parameter int WARM_CYC = CSR_WARM_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire csr_seq_s seq,
  input wire logic wdt_ovf,
  input wire logic bod_rst,
  input wire logic ext_rst_pin,
  input wire logic ret_valid,
  input wire logic global_irq_enable,
  input wire logic core_run,
  input wire logic stack_over
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic pop = seq.pop_sub | seq.pop_irq;
  wire logic quiet = !wdt_ovf && !bod_rst && ext_rst_pin;
  // Boot takes at least ten cycles, so eight idle cycles is a safe floor.
  sequence s_boot;
    !core_run [*8];
  endsequence
  sequence s_halt;
    !core_run [*3];
  endsequence
  a_boot_wait: assert property ($rose(aresetn) |-> s_boot)
    else $error("core ran before boot ended");
  a_wdt_halt: assert property (wdt_ovf |-> ##2 s_halt)
    else $error("core kept running after watchdog");
  a_bod_halt: assert property (bod_rst |-> ##2 s_halt)
    else $error("core kept running after brown-out");
  a_pop_answer: assert property (
    core_run && pop && !seq.push && quiet |=> ret_valid)
    else $error("pop gave no return address");
  a_ret_cause: assert property (ret_valid |-> $past(pop))
    else $error("return address without a pop");
  a_gie_reset: assert property ($rose(aresetn) |->
    !global_irq_enable && !stack_over && !ret_valid)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule : csr_call_stack_properties

bind csr_call_stack csr_call_stack_properties #(
  .SETTLE_CYC(SETTLE_CYC),
  .WARM_CYC(WARM_CYC)
) i_csr_call_stack_properties (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .seq, .wdt_ovf, .bod_rst, .ext_rst_pin, .ret_valid,
  .global_irq_enable, .core_run, .stack_over);

// ### verif/csr_seq_model.sv
`timescale 1ns/1ps
module csr_seq_model
  import csr_pkg::*;
(
  input wire logic aclk,
  input wire logic core_run,
  output csr_seq_s seq
);
  initial seq = '0;
  // A halted core drops requests, so each one waits for the core to run.
  task automatic issue(input logic [2:0] op, input logic [12:0] pc);
    @(posedge aclk);
    while (!core_run) @(posedge aclk);
    seq <= {op, pc};
    @(posedge aclk);
    seq <= {3'h0, ~pc};
  endtask : issue
endmodule : csr_seq_model

// ### verif/tb_csr_call_stack.sv
`timescale 1ns/1ps
module tb_csr_call_stack;
  import csr_pkg::*;
  localparam logic [11:0] A_FL = 12'h218;
  localparam logic [11:0] A_SP = 12'h37C;
  localparam logic [2:0] SRC [3] = '{3'h5, 3'h3, 3'h0};
  localparam logic [7:0] FLG [3] = '{8'h00, 8'h80, 8'hC0};
  localparam int HOLD [3] = '{2, 2, 20};
  logic aclk, aresetn, wdt_ovf, bod_rst, ext_rst_pin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ret_valid, global_irq_enable;
  logic core_run, stack_over;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] ret_pc;
  logic [12:0] pc [9];
  csr_seq_s seq;
  logic [33:0] rq [$];
  logic [12:0] pq [$];
  int bad_count, n_compared;

  csr_call_stack #(.SETTLE_CYC(4), .WARM_CYC(4)) i_csr_call_stack (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq,
    .wdt_ovf, .bod_rst, .ext_rst_pin, .ret_pc, .ret_valid,
    .global_irq_enable, .core_run, .stack_over);
  csr_seq_model i_csr_seq_model (.aclk, .core_run, .seq);

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Ready is sampled at the falling edge, where it has settled for the
  // rising edge that follows.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic da, dw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(da && dw)) begin
      @(negedge aclk);
      da = da | (s_axi_awvalid & s_axi_awready);
      dw = dw | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic wait_run();
    int n;
    n = 0;
    while (core_run !== 1'h1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk({33'h0, core_run}, 34'h1);
  endtask : wait_run

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata},
          rq.size() > 0 ? rq.pop_front() : '1);
    if (s_axi_bvalid && s_axi_bready)
      chk({32'h0, s_axi_bresp}, {32'h0, CSR_RESP_OKAY});
    if (ret_valid)
      chk({21'h0, ret_pc},
          pq.size() > 0 ? {21'h0, pq.pop_front()} : '1);
  end

  always #4 aclk = ~aclk;

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {aclk, aresetn, wdt_ovf, bod_rst} = '0;
    ext_rst_pin = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    void'($urandom(71746));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    wait_run();
    rd(A_SP, 34'h07);
    rd(A_FL, 34'h80);
    rd(12'h004, {CSR_RESP_SLVERR, 32'h0});
    wr(A_SP, 32'h07);
    for (int i = 0; i < 9; i++) begin
      pc[i] = 13'($urandom);
      i_csr_seq_model.issue(3'h4, pc[i]);
    end
    @(negedge aclk);
    chk({33'h0, stack_over}, 34'h1);
    rd(A_SP, 34'h06);
    rd(12'h3C0, {26'h0, pc[7][7:0]});
    rd(12'h3C4, {29'h0, pc[7][12:8]});
    rd(12'h3F8, {26'h0, pc[8][7:0]});
    for (int i = 8; i > 0; i--) begin
      pq.push_back(pc[i]);
      i_csr_seq_model.issue(i[0] ? 3'h1 : 3'h2, 13'h0);
    end
    rd(A_SP, 34'h06);
    wr(A_SP, 32'h87);
    @(negedge aclk);
    chk({33'h0, global_irq_enable}, 34'h1);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(12'h380, 32'h1);
      @(posedge aclk);
      {wdt_ovf, bod_rst, ext_rst_pin} <= SRC[i];
      repeat (HOLD[i]) @(posedge aclk);
      {wdt_ovf, bod_rst, ext_rst_pin} <= 3'h1;
      @(negedge aclk);
      chk({33'h0, core_run}, 34'h0);
      wait_run();
      rd(A_FL, {26'h0, FLG[i]});
      rd(A_SP, 34'h07);
    end
    report_and_stop();
  end
endmodule : tb_csr_call_stack
